// File: shared/wco_defines.svh
// constants for the watchdog clear and complement execution slice
`ifndef WCO_DEFINES_SVH
`define WCO_DEFINES_SVH
`define WCO_DATA_W 8
`define WCO_ADDR_W 8
`define WCO_MEM_DEPTH 160
`define WCO_WDT_W 8
`define WCO_WDT_CLEAR 8'h00
`define WCO_FLAG_RESET 1'b0
`endif

// File: shared/wco_pkg.sv
// types for the watchdog clear and complement execution slice
package wco_pkg;
  typedef enum logic [4:0] {
    WCO_OP_NONE = 5'b00001,
    WCO_OP_WDT_CLEAR = 5'b00010,
    WCO_OP_PRECLEAR1 = 5'b00100,
    WCO_OP_PRECLEAR2 = 5'b01000,
    WCO_OP_COMPLEMENT = 5'b10000
  } wco_op_t;
endpackage

// File: shared/wco_mem_if.sv
// data memory access signals between the slice and its storage
`timescale 1ns/1ns
`include "wco_defines.svh"
interface wco_mem_if;
  logic [`WCO_ADDR_W-1:0] addr;
  logic [`WCO_DATA_W-1:0] rdata;
  logic [`WCO_DATA_W-1:0] wdata;
  logic we;
  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// File: rtl/wco_data_mem.sv
// flip-flop data memory with one port whose single address serves both read and write
`timescale 1ns/1ns
`include "wco_defines.svh"
module wco_data_mem
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // access port
  wco_mem_if.mem bus
);
  logic [`WCO_DATA_W-1:0] store [`WCO_MEM_DEPTH];
  logic in_range;
  assign in_range = 32'(bus.addr) < `WCO_MEM_DEPTH;
  assign bus.rdata = in_range ? store[bus.addr] : '0;
  genvar gi;
  generate
    for (gi = 0; gi < `WCO_MEM_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          store[gi] <= '0;
        else if (bus.we && 32'(bus.addr) == gi)
          store[gi] <= bus.wdata;
      end
    end
  endgenerate
endmodule // wco_data_mem

// File: rtl/wco_exec.sv
// watchdog clear, preclear pairing and memory complement execution
// Summary of operation
// - single clear zeroes watchdog counter and clears power-down and timeout flags
// - preclear after its partner zeroes counter and clears both flags
// - pairing works in either order; second arrival completes the clear
// - lone preclear sets its own indicator and leaves counter running
// - lone preclear leaves timeout and power-down flags unchanged
// - complement inverts addressed data byte and writes it back in place; at addresses 160 and up it reads zero and writes nothing
`timescale 1ns/1ns
`include "wco_defines.svh"
module wco_exec
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // decoded instruction
  input wire logic op_valid,
  input wire wco_pkg::wco_op_t op,
  input wire logic [`WCO_ADDR_W-1:0] op_addr,
  // watchdog and status events from the rest of the core
  input wire logic wdt_tick,
  input wire logic timeout_set,
  input wire logic power_down_set,
  // observed state
  output logic [`WCO_WDT_W-1:0] watchdog_counter,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic first_preclear_seen,
  output logic second_preclear_seen,
  output logic [`WCO_DATA_W-1:0] complement_result,
  output logic complement_done
);
  wco_mem_if mem_bus ();

  wco_data_mem u_mem
  (
    .core_clk(core_clk),
    .reset(reset),
    .bus(mem_bus)
  );

  // decode
  logic do_clear;
  logic do_pre1;
  logic do_pre2;
  logic do_cpl;
  logic pair_done;
  logic wdt_zero;
  logic lone_pre;
  assign do_clear = op_valid && op == wco_pkg::WCO_OP_WDT_CLEAR;
  assign do_pre1 = op_valid && op == wco_pkg::WCO_OP_PRECLEAR1;
  assign do_pre2 = op_valid && op == wco_pkg::WCO_OP_PRECLEAR2;
  assign do_cpl = op_valid && op == wco_pkg::WCO_OP_COMPLEMENT;
  // second half of pair, either order
  assign pair_done = (do_pre1 && second_preclear_seen) ||
                     (do_pre2 && first_preclear_seen);
  assign wdt_zero = do_clear || pair_done;
  // preclear with no partner pending
  assign lone_pre = (do_pre1 && !second_preclear_seen) ||
                    (do_pre2 && !first_preclear_seen);

  // next values
  logic [`WCO_WDT_W-1:0] next_counter;
  logic next_timeout;
  logic next_power_down;
  logic next_pre1;
  logic next_pre2;
  assign next_counter = wdt_zero ? `WCO_WDT_CLEAR :
                        wdt_tick ? watchdog_counter + 8'h01 : watchdog_counter;
  // clear instruction takes priority over a same-cycle set
  assign next_timeout = wdt_zero ? 1'b0 : (timeout_flag || timeout_set);
  assign next_power_down = wdt_zero ? 1'b0 : (power_down_flag || power_down_set);
  assign next_pre1 = pair_done ? 1'b0 : (first_preclear_seen || do_pre1);
  assign next_pre2 = pair_done ? 1'b0 : (second_preclear_seen || do_pre2);

  // memory complement in place
  assign mem_bus.addr = op_addr;
  assign mem_bus.wdata = ~mem_bus.rdata;
  assign mem_bus.we = do_cpl;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      watchdog_counter <= `WCO_WDT_CLEAR;
      timeout_flag <= `WCO_FLAG_RESET;
      power_down_flag <= `WCO_FLAG_RESET;
      first_preclear_seen <= 1'b0;
      second_preclear_seen <= 1'b0;
    end
    else
    begin
      watchdog_counter <= next_counter;
      timeout_flag <= next_timeout;
      power_down_flag <= next_power_down;
      first_preclear_seen <= next_pre1;
      second_preclear_seen <= next_pre2;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      complement_result <= '0;
      complement_done <= 1'b0;
    end
    else
    begin
      complement_done <= do_cpl;
      if (do_cpl)
        complement_result <= mem_bus.wdata;
    end
  end

  // checks
  property p_single_clear;
    @(posedge core_clk) disable iff (reset)
    do_clear |=> watchdog_counter == 8'h00 && !timeout_flag && !power_down_flag;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("clear did not zero");

  property p_pair_clear;
    @(posedge core_clk) disable iff (reset)
    do_pre2 && first_preclear_seen |=> watchdog_counter == 8'h00 && !timeout_flag;
  endproperty
  a_pair_clear: assert property (p_pair_clear) else $error("pair did not clear");

  property p_either_order;
    @(posedge core_clk) disable iff (reset)
    do_pre1 && second_preclear_seen |=> watchdog_counter == 8'h00 && !power_down_flag;
  endproperty
  a_either_order: assert property (p_either_order) else $error("reverse pair failed");

  property p_lone_sets;
    @(posedge core_clk) disable iff (reset)
    do_pre1 && !second_preclear_seen |=> first_preclear_seen;
  endproperty
  a_lone_sets: assert property (p_lone_sets) else $error("indicator not set");

  property p_lone_keeps_flags;
    @(posedge core_clk) disable iff (reset)
    do_pre2 && !first_preclear_seen && timeout_flag |=> timeout_flag;
  endproperty
  a_lone_keeps_flags: assert property (p_lone_keeps_flags) else $error("flag lost");

  property p_complement;
    @(posedge core_clk) disable iff (reset)
    do_cpl |=> complement_done && complement_result == ~$past(mem_bus.rdata);
  endproperty
  a_complement: assert property (p_complement) else $error("complement wrong");

  property p_pair_resets;
    @(posedge core_clk) disable iff (reset)
    pair_done |=> !first_preclear_seen && !second_preclear_seen;
  endproperty
  a_pair_resets: assert property (p_pair_resets) else $error("indicators kept");

  // preclear indicator and lone preclear counter checks
  property p_lone_sets_b;
    @(posedge core_clk) disable iff (reset)
    do_pre2 && !first_preclear_seen |=> second_preclear_seen;
  endproperty
  a_lone_sets_b: assert property (p_lone_sets_b) else $error("no indicator");

  property p_single_keeps_ind;
    @(posedge core_clk) disable iff (reset)
    do_clear |=> $stable(first_preclear_seen) && $stable(second_preclear_seen);
  endproperty
  a_single_keeps_ind: assert property (p_single_keeps_ind) else $error("ind lost");

  property p_lone_counts;
    @(posedge core_clk) disable iff (reset)
    lone_pre && wdt_tick |=> watchdog_counter == $past(watchdog_counter) + 8'h01;
  endproperty
  a_lone_counts: assert property (p_lone_counts) else $error("lone stopped count");

  property p_lone_holds;
    @(posedge core_clk) disable iff (reset)
    lone_pre && !wdt_tick |=> $stable(watchdog_counter);
  endproperty
  a_lone_holds: assert property (p_lone_holds) else $error("lone moved count");

  // status flag checks
  property p_lone_keeps_to;
    @(posedge core_clk) disable iff (reset)
    lone_pre && !timeout_set |=> $stable(timeout_flag);
  endproperty
  a_lone_keeps_to: assert property (p_lone_keeps_to) else $error("timeout moved");

  property p_lone_keeps_pd;
    @(posedge core_clk) disable iff (reset)
    lone_pre && !power_down_set |=> $stable(power_down_flag);
  endproperty
  a_lone_keeps_pd: assert property (p_lone_keeps_pd) else $error("power-down moved");

  property p_pair_clear_pd;
    @(posedge core_clk) disable iff (reset)
    do_pre2 && first_preclear_seen |=> !power_down_flag;
  endproperty
  a_pair_clear_pd: assert property (p_pair_clear_pd) else $error("pair kept pd");

  property p_either_to;
    @(posedge core_clk) disable iff (reset)
    do_pre1 && second_preclear_seen |=> !timeout_flag && !first_preclear_seen;
  endproperty
  a_either_to: assert property (p_either_to) else $error("reverse pair kept");

  property p_clear_beats_set;
    @(posedge core_clk) disable iff (reset)
    do_clear && (timeout_set || power_down_set) |=> !timeout_flag && !power_down_flag;
  endproperty
  a_clear_beats_set: assert property (p_clear_beats_set) else $error("set beat clear");

  // complement checks
  property p_done_pulse;
    @(posedge core_clk) disable iff (reset)
    !do_cpl |=> !complement_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");

  property p_result_holds;
    @(posedge core_clk) disable iff (reset)
    !do_cpl |=> $stable(complement_result);
  endproperty
  a_result_holds: assert property (p_result_holds) else $error("result moved");
endmodule // wco_exec

// File: verif/wdt_clear_and_complement_ops_test.sv
// self-checking bench for the watchdog clear and complement slice
`timescale 1ns/1ns
`include "wco_defines.svh"
`define CHK(g, e, s) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t %s", $time, s); end end
module wdt_clear_and_complement_ops_test;
  localparam wco_pkg::wco_op_t NO = wco_pkg::WCO_OP_NONE;
  localparam wco_pkg::wco_op_t CL = wco_pkg::WCO_OP_WDT_CLEAR;
  localparam wco_pkg::wco_op_t P1 = wco_pkg::WCO_OP_PRECLEAR1;
  localparam wco_pkg::wco_op_t P2 = wco_pkg::WCO_OP_PRECLEAR2;
  localparam wco_pkg::wco_op_t CP = wco_pkg::WCO_OP_COMPLEMENT;
  typedef struct packed {logic [7:0] cnt; logic to; logic pd; logic f1; logic f2;
    logic [7:0] res; logic done;} wco_note_t;
  logic core_clk, reset, op_valid, wdt_tick, timeout_set, power_down_set;
  logic to_f, pd_f, f1, f2, done;
  logic [7:0] op_addr, cnt, res;
  logic [31:0] r;
  bit took;
  wco_pkg::wco_op_t op, o;
  wco_note_t m, n;
  wco_note_t notes[$];
  logic [7:0] mem [0:255];
  int failures, checks, i;
  wco_exec uut (.core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op(op),
    .op_addr(op_addr), .wdt_tick(wdt_tick), .timeout_set(timeout_set),
    .power_down_set(power_down_set), .watchdog_counter(cnt), .timeout_flag(to_f),
    .power_down_flag(pd_f), .first_preclear_seen(f1), .second_preclear_seen(f2),
    .complement_result(res), .complement_done(done));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // drive one instruction and note the expected state
  task automatic step(wco_pkg::wco_op_t x, logic [7:0] a, logic t, logic ts, logic ps);
    logic clr;
    clr = (x == CL) || (x == P1 && m.f2) || (x == P2 && m.f1);
    @(negedge core_clk);
    op_valid = 1'b1;
    op = x;
    op_addr = a;
    wdt_tick = t;
    timeout_set = ts;
    power_down_set = ps;
    m.cnt = t ? m.cnt + 8'h01 : m.cnt;
    m.to = m.to | ts;
    m.pd = m.pd | ps;
    m.done = 1'b0;
    if (clr)
    begin
      m.cnt = `WCO_WDT_CLEAR;
      m.to = 1'b0;
      m.pd = 1'b0;
      if (x != CL) m.f1 = 1'b0;
      if (x != CL) m.f2 = 1'b0;
    end
    else if (x == P1) m.f1 = 1'b1;
    else if (x == P2) m.f2 = 1'b1;
    else if (x == CP)
    begin
      m.res = ~mem[a];
      m.done = 1'b1;
      if (a < `WCO_MEM_DEPTH) mem[a] = m.res;
    end
    notes.push_back(m);
  endtask
  task automatic idle();
    @(negedge core_clk);
    op_valid = 1'b0;
    wdt_tick = 1'b0;
    timeout_set = 1'b0;
    power_down_set = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) took <= op_valid & ~reset;
  always @(negedge core_clk)
    if (took)
    begin
      if (notes.size() == 0) `CHK(1'b1, 1'b0, "no note")
      else
      begin
        n = notes.pop_front();
        `CHK(cnt, n.cnt, "counter")
        `CHK(to_f, n.to, "timeout flag")
        `CHK(pd_f, n.pd, "power-down flag")
        `CHK(f1, n.f1, "first indicator")
        `CHK(f2, n.f2, "second indicator")
        `CHK(done, n.done, "complement done")
        if (n.done) `CHK(res, n.res, "complement result")
      end
    end
  initial
  begin
    {reset, op_valid, wdt_tick, timeout_set, power_down_set} = 5'h10;
    op = NO;
    op_addr = 8'h00;
    m = '0;
    for (i = 0; i < 256; i++) mem[i] = 8'h00;
    r = $urandom(32'h487bf5d1);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    step(NO, 8'h00, 1'b1, 1'b1, 1'b1);
    step(P1, 8'h00, 1'b1, 1'b0, 1'b0);
    step(P1, 8'h00, 1'b1, 1'b0, 1'b0);
    step(P2, 8'h00, 1'b1, 1'b1, 1'b0);
    step(NO, 8'h00, 1'b1, 1'b1, 1'b1);
    step(P2, 8'h00, 1'b1, 1'b0, 1'b0);
    step(P1, 8'h00, 1'b0, 1'b0, 1'b1);
    step(CL, 8'h00, 1'b0, 1'b1, 1'b1);
    step(CP, 8'h9f, 1'b0, 1'b0, 1'b0);
    step(CP, 8'h9f, 1'b0, 1'b0, 1'b0);
    step(CP, 8'ha0, 1'b0, 1'b0, 1'b0);
    idle();
    $display("test directed done");
    for (i = 0; i < 1500; i++)
    begin
      r = $urandom;
      o = r[26:24] % 5 == 0 ? NO : r[26:24] % 5 == 1 ? CL : r[26:24] % 5 == 2 ? P1 :
        r[26:24] % 5 == 3 ? P2 : CP;
      step(o, r[0] ? {6'h00, r[2:1]} : r[15:8], r[16], r[17] & r[18], r[19] & r[20]);
    end
    idle();
    $display("test random done");
    for (i = 0; i < 4 && notes.size() != 0; i++) @(negedge core_clk);
    if (notes.size() != 0) `CHK(1'b1, 1'b0, "results missing")
    @(negedge core_clk) reset = 1'b1;
    m = '0;
    for (i = 0; i < 256; i++) mem[i] = 8'h00;
    @(negedge core_clk) reset = 1'b0;
    `CHK({cnt, to_f, pd_f, f1, f2, res, done}, 21'h0, "reset state")
    step(P2, 8'h01, 1'b0, 1'b0, 1'b0);
    step(CP, 8'h01, 1'b0, 1'b0, 1'b0);
    idle();
    for (i = 0; i < 4 && notes.size() != 0; i++) @(negedge core_clk);
    if (notes.size() != 0) `CHK(1'b1, 1'b0, "reset results missing")
    $display("test reset done");
    close_out();
  end
endmodule // wdt_clear_and_complement_ops_test
